// >>> bst_pkg.sv
// Shared constants, state encoding and carriers of the boundary-scan port.
// Assumes a single core clock domain; test pins arrive from outside it.
package bst_pkg;

    // ----------------------------------------------------------------
    // Register sizes
    // ----------------------------------------------------------------
    localparam int IR_W = 8;
    localparam int BSR_W = 113;
    localparam int ID_W = 32;

    // ----------------------------------------------------------------
    // Instruction codes
    // ----------------------------------------------------------------
    localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
    localparam logic [IR_W-1:0] OP_SAMPLE = 8'h05;
    localparam logic [IR_W-1:0] OP_BYPASS = 8'hff;
    localparam logic [IR_W-1:0] OP_IDCODE = 8'h21;
    localparam logic [IR_W-1:0] OP_CLAMP = 8'h07;
    localparam logic [IR_W-1:0] OP_HIGHZ = 8'h03;
    // Pattern loaded into the instruction stage on capture
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 8'h01;

    // ----------------------------------------------------------------
    // Identification code fields (values arbitrary, not a real part)
    // ----------------------------------------------------------------
    localparam logic [3:0] ID_REV_DEF = 4'h1;
    localparam logic [15:0] ID_PART_DEF = 16'h0123;
    localparam logic [10:0] ID_MAKER_DEF = 11'h055;
    localparam logic ID_PRESENT = 1'b1;

    // ----------------------------------------------------------------
    // Controller states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PAU_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PAU_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } bst_state_type;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_pins_type;

    typedef struct packed {
        logic test_drive;
        logic force_hiz;
    } bst_mode_type;

endpackage

// >>> bst_sync.sv
// Two-stage synchroniser for a bus of independent levels.
// Assumes each bit is a quasi-static level or a slow test signal.
`timescale 1ns/10ps
`default_nettype none
module bst_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // ----------------------------------------------------------------
    // Capture chain; first stage feeds only the second
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else if (ce) begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule
`default_nettype wire

// >>> bst_fsm.sv
// Sixteen-state test controller, stepped once per sampled test clock rise.
// Assumes step is a one-cycle pulse on the core clock.
`timescale 1ns/10ps
`default_nettype none
module bst_fsm (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic step,
    input wire logic tms,
    output bst_pkg::bst_state_type state
);
    import bst_pkg::*;

    bst_state_type state_r;
    bst_state_type state_nxt;

    // ----------------------------------------------------------------
    // Next state; five high mode-select steps reach reset from anywhere
    // ----------------------------------------------------------------
    always_comb begin
        case (state_r)
            ST_TLR: state_nxt = tms ? ST_TLR : ST_RTI;
            ST_RTI: state_nxt = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_nxt = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
            default: state_nxt = ST_TLR;
        endcase
    end

    // ----------------------------------------------------------------
    // State register, reset to test-logic reset
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_TLR;
        end else if (ce && step) begin
            state_r <= state_nxt;
        end
    end

    assign state = state_r;
endmodule
`default_nettype wire

// >>> bst_tap_top.sv
// Boundary-scan test access port of a separate-I/O memory device.
// Assumes core_clk is much faster than the test clock, which is sampled.
// Ring inputs come from pads; functional outputs come from core logic.
//
// Overview of operation
// - Mode select and data-in taken at test clock rise; data-out at fall.
// - Serial data-in enters the most significant bit of the selected path.
// - Data-out shows the least significant bit; paths shift toward it.
// - Data-out driver enabled only in Shift-IR and Shift-DR.
// - Five rising edges with mode select high reach test-logic reset.
// - Test reset never disturbs normal memory operation.
// - Power-up resets the port internally; data-out starts undriven.
// - Exactly one scan path is connected, chosen by active instruction.
// - Active instruction changes only in Update-IR and Test-Logic-Reset, never while shifting.
// - Capture-IR loads pattern 01 into the two lowest bits.
// - Instruction 8 bits, boundary chain 113 bits, identity 32 bits.
// - Bypass is one bit, cleared when the bypass path is captured.
// - Capture-DR loads ring contents; Shift-DR shifts the chain.
// - Identity instruction captures the fixed code and shifts it out.
// - Identity instruction is active after power-up and test reset.
// - EXTEST drives preloaded outputs from Update-IR, captures inputs.
// - High-Z selects bypass and floats every memory output.
// - CLAMP drives output balls from the held boundary values.
// - SAMPLE/PRELOAD captures all input balls, outputs untouched.
// - Codes: EXTEST 00, SAMPLE/PRELOAD 05, BYPASS ff.
// - Codes: identity 21, CLAMP 07, High-Z 03.
// - CLAMP connects the one-bit bypass path.
// - Identity code bit zero always reads one.
`timescale 1ns/10ps
`default_nettype none
module bst_tap_top #(
    parameter logic [3:0] ID_REV = bst_pkg::ID_REV_DEF,
    parameter logic [15:0] ID_PART = bst_pkg::ID_PART_DEF,
    parameter logic [10:0] ID_MAKER = bst_pkg::ID_MAKER_DEF
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire bst_pkg::bst_pins_type tap_pins,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [bst_pkg::BSR_W-1:0] ring_in,
    input wire logic [bst_pkg::BSR_W-1:0] func_out,
    output logic [bst_pkg::BSR_W-1:0] ring_out,
    output bst_pkg::bst_mode_type ring_mode,
    output logic [bst_pkg::IR_W-1:0] ir_active
);
    import bst_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n;

    // Async assert, sync release; a glitchy release would split state
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    assign rst_n = rst_sync_r;

    // ----------------------------------------------------------------
    // Pin sampling and test clock edges
    // ----------------------------------------------------------------
    logic [2:0] pins_w;
    bst_pins_type pins_s;
    logic tck_prev_r;
    logic tck_rise;
    logic tck_fall;

    bst_sync #(
        .W(3)
    ) u_pin_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(tap_pins),
        .q(pins_w)
    );

    assign pins_s = pins_w;

    // Previous sampled clock level for edge finding
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_prev_r <= 1'b0;
        end else if (ce) begin
            tck_prev_r <= pins_s.tck;
        end
    end

    // Edge strobes; mode select and data-in share the same delay
    assign tck_rise = pins_s.tck & ~tck_prev_r;
    assign tck_fall = ~pins_s.tck & tck_prev_r;

    // ----------------------------------------------------------------
    // Ring input sampling
    // ----------------------------------------------------------------
    logic [BSR_W-1:0] ring_in_s;

    // Pads may move during capture; synchronising keeps the value clean
    bst_sync #(
        .W(BSR_W)
    ) u_ring_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(ring_in),
        .q(ring_in_s)
    );

    // ----------------------------------------------------------------
    // Controller
    // ----------------------------------------------------------------
    bst_state_type state;

    bst_fsm u_fsm (
        .clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .step(tck_rise),
        .tms(pins_s.tms),
        .state(state)
    );

    // State decodes
    logic in_tlr;
    logic cap_ir;
    logic sh_ir;
    logic upd_ir;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;

    assign in_tlr = (state == ST_TLR);
    assign cap_ir = (state == ST_CAP_IR);
    assign sh_ir = (state == ST_SH_IR);
    assign upd_ir = (state == ST_UPD_IR);
    assign cap_dr = (state == ST_CAP_DR);
    assign sh_dr = (state == ST_SH_DR);
    assign upd_dr = (state == ST_UPD_DR);

    // ----------------------------------------------------------------
    // Instruction stage and active instruction
    // ----------------------------------------------------------------
    logic [IR_W-1:0] ir_sh_r;
    logic [IR_W-1:0] ir_r;

    // Shift stage: capture pattern, then shift toward bit zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_r <= IR_CAPTURE_VAL;
        end else if (ce && tck_rise) begin
            if (cap_ir) begin
                ir_sh_r <= IR_CAPTURE_VAL;
            end else if (sh_ir) begin
                ir_sh_r <= {pins_s.tdi, ir_sh_r[IR_W-1:1]};
            end
        end
    end

    // Active instruction only moves on update or test-logic reset; shifting leaves it alone
    // Test-logic reset loads it at once, not a test clock period late
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_r <= OP_IDCODE;
        end else if (ce) begin
            if (in_tlr) begin
                ir_r <= OP_IDCODE;
            end else if (tck_rise && upd_ir) begin
                ir_r <= ir_sh_r;
            end
        end
    end

    assign ir_active = ir_r;

    // ----------------------------------------------------------------
    // Instruction decode
    // ----------------------------------------------------------------
    logic op_extest;
    logic op_sample;
    logic op_idcode;
    logic op_clamp;
    logic op_highz;
    logic sel_bsr;
    logic sel_id;
    logic sel_byp;

    assign op_extest = (ir_r == OP_EXTEST);
    assign op_sample = (ir_r == OP_SAMPLE);
    assign op_idcode = (ir_r == OP_IDCODE);
    assign op_clamp = (ir_r == OP_CLAMP);
    assign op_highz = (ir_r == OP_HIGHZ);

    // One path only; bypass also takes reserved codes so the chain holds
    assign sel_bsr = op_extest | op_sample;
    assign sel_id = op_idcode;
    assign sel_byp = ~sel_bsr & ~sel_id;

    // Shift strobes; one core cycle per sampled rise, gated by path
    logic step_en;
    logic byp_step;
    logic id_step;
    logic bsr_step;

    assign step_en = ce & tck_rise;
    assign byp_step = step_en & sel_byp;
    assign id_step = step_en & sel_id;
    assign bsr_step = step_en & sel_bsr;

    // ----------------------------------------------------------------
    // Data registers
    // ----------------------------------------------------------------
    logic byp_r;
    logic [ID_W-1:0] id_sh_r;
    logic [BSR_W-1:0] bsr_r;
    logic [BSR_W-1:0] bsr_upd_r;
    logic [ID_W-1:0] id_code;

    // Fixed identity word; presence bit forced to one
    assign id_code = {ID_REV, ID_PART, ID_MAKER, ID_PRESENT};

    // Single-bit bypass, cleared on capture of the bypass path
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            byp_r <= 1'b0;
        end else if (byp_step) begin
            if (cap_dr) begin
                byp_r <= 1'b0;
            end else if (sh_dr) begin
                byp_r <= pins_s.tdi;
            end
        end
    end

    // Identity shift stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            id_sh_r <= '0;
        end else if (id_step) begin
            if (cap_dr) begin
                id_sh_r <= id_code;
            end else if (sh_dr) begin
                id_sh_r <= {pins_s.tdi, id_sh_r[ID_W-1:1]};
            end
        end
    end

    // Boundary chain: capture ring, shift one cell per ball
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bsr_r <= '0;
        end else if (bsr_step) begin
            if (cap_dr) begin
                bsr_r <= ring_in_s;
            end else if (sh_dr) begin
                bsr_r <= {pins_s.tdi, bsr_r[BSR_W-1:1]};
            end
        end
    end

    // Held values: preload lands here and feeds the output cells
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bsr_upd_r <= '0;
        end else if (bsr_step && upd_dr) begin
            bsr_upd_r <= bsr_r;
        end
    end

    // ----------------------------------------------------------------
    // Serial output
    // ----------------------------------------------------------------
    logic dr_lsb;
    logic tdo_nxt;
    logic tdo_r;
    logic tdo_oe_r;

    assign dr_lsb = sel_bsr ? bsr_r[0] : (sel_id ? id_sh_r[0] : byp_r);
    assign tdo_nxt = sh_ir ? ir_sh_r[0] : dr_lsb;

    // Updated on the falling edge only, half a period after the shift
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else if (ce && tck_fall) begin
            tdo_r <= tdo_nxt;
            tdo_oe_r <= sh_ir | sh_dr;
        end
    end

    assign tdo = tdo_r;
    assign tdo_oe = tdo_oe_r;

    // ----------------------------------------------------------------
    // Ball control
    // ----------------------------------------------------------------
    bst_mode_type mode_r;
    bst_mode_type mode_nxt;
    logic [BSR_W-1:0] ring_out_r;
    logic [BSR_W-1:0] ring_out_nxt;

    logic drive_test;
    logic float_outs;

    // Test drive follows the active instruction, so it starts at update
    assign drive_test = op_extest | op_clamp;
    assign float_outs = op_highz;
    // One assignment for the whole carrier keeps a single driver
    assign mode_nxt = '{test_drive: drive_test, force_hiz: float_outs};
    // Sample, identity and bypass pass core values through untouched
    assign ring_out_nxt = drive_test ? bsr_upd_r : func_out;

    // Reset mode is functional, so a test reset never upsets the memory
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= '0;
            ring_out_r <= '0;
        end else if (ce) begin
            mode_r <= mode_nxt;
            ring_out_r <= ring_out_nxt;
        end
    end

    assign ring_mode = mode_r;
    assign ring_out = ring_out_r;
endmodule
`default_nettype wire

// >>> bst_tester.sv
// Test controller model: drives test pins and runs IR and DR scans.
// Assumes core_clk paces it; tck moves only inside its tasks.
`timescale 1ns/10ps
`default_nettype none
module bst_tester (
    input wire logic core_clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output bst_pkg::bst_pins_type pins
);
    logic oe_all;

    // --------------------------------------------------------------
    // Pin activity
    // --------------------------------------------------------------
    // Mode select and data-in rest high, as the pull-ups would leave them; tck rests low
    initial pins = 3'b011;

    // One 160 ns period; tdo read mid high phase, where it is settled
    task automatic tick(input logic tms, input logic tdi, output logic o);
        pins.tms = tms;
        pins.tdi = tdi;
        repeat (4) @(posedge core_clk);
        #1 pins.tck = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 o = tdo;
        repeat (2) @(posedge core_clk);
        #1 pins.tck = 1'b0;
    endtask

    // Five rises with mode select high, then park in idle
    task automatic tap_reset();
        logic o;
        repeat (5) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask

    // Idle to shift, n bits LSB first, then update and back to idle
    task automatic scan(input logic ir, input logic [127:0] din,
                        input int n, output logic [127:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b1, o);
        if (ir) begin
            tick(1'b1, 1'b1, o);
        end
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        oe_all = 1'b1;
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
            oe_all = oe_all & tdo_oe;
        end
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask
endmodule
`default_nettype wire

// >>> bst_tap_top_sva.sv
// Checker for the boundary-scan port, bound to the top module.
// Assumes tck is much slower than core_clk and moves after its edge.
`timescale 1ns/10ps
`default_nettype none
module bst_tap_sva
    import bst_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire bst_pkg::bst_pins_type tap_pins,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [bst_pkg::BSR_W-1:0] ring_in,
    input wire logic [bst_pkg::BSR_W-1:0] func_out,
    input wire logic [bst_pkg::BSR_W-1:0] ring_out,
    input wire bst_pkg::bst_mode_type ring_mode,
    input wire logic [bst_pkg::IR_W-1:0] ir_active
);
    logic tck_r, tms_r;
    logic [3:0] rise_age_r, fall_age_r, ones_r;
    logic [2:0] live_r;
    wire logic rise = tap_pins.tck & ~tck_r;
    wire logic fall = ~tap_pins.tck & tck_r;

    // --------------------------------------------------------------
    // Edge ages and mode select history
    // --------------------------------------------------------------
    // Ages saturate so a long idle never wraps into a false match
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tck_r <= 1'b0;
            tms_r <= 1'b1;
            rise_age_r <= 4'hf;
            fall_age_r <= 4'hf;
            ones_r <= 4'h0;
            live_r <= 3'h0;
        end else begin
            tck_r <= tap_pins.tck;
            rise_age_r <= rise ? 4'h0 : rise_age_r + 4'(rise_age_r != 4'hf);
            fall_age_r <= fall ? 4'h0 : fall_age_r + 4'(fall_age_r != 4'hf);
            live_r <= live_r + 3'(live_r != 3'h5);
            if (rise) begin
                tms_r <= tap_pins.tms;
                ones_r <= !tap_pins.tms ? 4'h0 : ones_r + 4'(ones_r != 4'h7);
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_five_ones;
        $rose(ones_r == 4'h5);
    endsequence

    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    a_tdo_on_fall: assert property (
        $changed(tdo) |-> fall_age_r <= 4'h6)
        else $error("tdo moved away from a tck fall");
    a_oe_on_fall: assert property (
        $changed(tdo_oe) |-> fall_age_r <= 4'h6)
        else $error("tdo_oe moved away from a tck fall");
    a_oe_needs_shift: assert property (
        $rose(tdo_oe) |-> !tms_r)
        else $error("tdo_oe rose without a shift entry");
    a_ir_on_rise: assert property (
        $changed(ir_active) |-> rise_age_r <= 4'h6)
        else $error("instruction changed away from a tck rise");
    a_ir_reset_val: assert property (
        $rose(rstn) |-> (ir_active == OP_IDCODE && !tdo_oe) [*3])
        else $error("wrong state after reset release");
    a_tms_reset: assert property (
        s_five_ones |-> ##[1:8] ir_active == OP_IDCODE)
        else $error("five high tms rises did not reset");
    a_drive_mode: assert property (
        ring_mode.test_drive ==
        ($past(ir_active) == OP_EXTEST || $past(ir_active) == OP_CLAMP))
        else $error("test_drive does not follow instruction");
    a_hiz_mode: assert property (
        ring_mode.force_hiz == ($past(ir_active) == OP_HIGHZ))
        else $error("force_hiz does not follow instruction");
    a_ring_pass: assert property (
        live_r == 3'h5 && !$past(ring_mode.test_drive) &&
        !ring_mode.test_drive |-> ring_out == $past(func_out))
        else $error("ring_out not passing func_out");
endmodule

bind bst_tap_top bst_tap_sva u_sva (.core_clk(core_clk), .rstn(rstn),
    .ce(ce), .tap_pins(tap_pins), .tdo(tdo), .tdo_oe(tdo_oe),
    .ring_in(ring_in), .func_out(func_out), .ring_out(ring_out),
    .ring_mode(ring_mode), .ir_active(ir_active));
`default_nettype wire

// >>> bst_tap_top_tb.sv
// Self-checking bench for the boundary-scan port.
// Assumes the tester model paces tck from core_clk.
`timescale 1ns/10ps
`default_nettype none
module bst_tap_top_tb;
    import bst_pkg::*;
    logic core_clk, rstn, tdo, tdo_oe;
    bst_pins_type pins;
    logic [BSR_W-1:0] ring_in, func_out, ring_out, pre;
    bst_mode_type ring_mode;
    logic [IR_W-1:0] ir_active;
    logic [127:0] d;
    int error_cnt, num_checks;

    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    bst_tap_top DUT (.core_clk(core_clk), .rstn(rstn), .ce(1'b1),
        .tap_pins(pins), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in),
        .func_out(func_out), .ring_out(ring_out), .ring_mode(ring_mode),
        .ir_active(ir_active));
    bst_tester TST (.core_clk(core_clk), .tdo(tdo), .tdo_oe(tdo_oe),
        .pins(pins));

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [127:0] exp,
                       input logic [127:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    // Load an instruction; capture must return the fixed pattern
    task automatic ld(input logic [IR_W-1:0] op);
        TST.scan(1'b1, 128'(op), IR_W, d);
        chk("ir_capture", 128'(IR_CAPTURE_VAL), d);
        chk("ir_active", 128'(op), 128'(ir_active));
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog well above the roughly 63 us the tests need
    initial begin
        #400000;
        error_cnt++;
        summarize();
    end

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        ring_in = {1'b1, {7{16'hc3a5}}};
        func_out = {1'b0, {7{16'h9696}}};
        pre = {1'b0, {7{16'h5e21}}};
        repeat (20) @(posedge core_clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk("ir_reset", 128'(OP_IDCODE), 128'(ir_active));
        chk("oe_reset", 128'h0, 128'(tdo_oe));
        TST.tap_reset();
        TST.scan(1'b0, 128'h0, ID_W, d);
        chk("idcode", {ID_REV_DEF, ID_PART_DEF, ID_MAKER_DEF, 1'b1},
            d);
        chk("oe_shift", 128'h1, 128'(TST.oe_all));
        chk("oe_idle", 128'h0, 128'(tdo_oe));
        ld(OP_BYPASS);
        TST.scan(1'b0, 128'h3, 2, d);
        chk("bypass", 128'h2, d);
        ld(OP_SAMPLE);
        TST.scan(1'b0, 128'(pre), BSR_W, d);
        chk("sample", 128'(ring_in), d);
        chk("sample_mode", 128'h0, 128'(ring_mode));
        chk("sample_out", 128'(func_out), 128'(ring_out));
        ring_in = {1'b0, {7{16'h0ff0}}};
        ld(OP_EXTEST);
        chk("extest_mode", 128'h2, 128'(ring_mode));
        chk("extest_out", 128'(pre), 128'(ring_out));
        TST.scan(1'b0, 128'(pre), BSR_W, d);
        chk("extest_cap", 128'(ring_in), d);
        ld(OP_CLAMP);
        chk("clamp_out", 128'(pre), 128'(ring_out));
        TST.scan(1'b0, 128'h3, 2, d);
        chk("clamp_path", 128'h2, d);
        ld(OP_HIGHZ);
        chk("hiz_mode", 128'h1, 128'(ring_mode));
        TST.scan(1'b0, 128'h3, 2, d);
        chk("hiz_path", 128'h2, d);
        func_out = {1'b1, {7{16'h3c3c}}};
        TST.tap_reset();
        chk("tap_reset_ir", 128'(OP_IDCODE), 128'(ir_active));
        chk("tap_reset_mode", 128'h0, 128'(ring_mode));
        chk("tap_reset_out", 128'(func_out), 128'(ring_out));
        ld(OP_HIGHZ);
        @(posedge core_clk);
        #1 rstn = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk("rerst_ir", 128'(OP_IDCODE), 128'(ir_active));
        chk("rerst_oe", 128'h0, 128'(tdo_oe));
        summarize();
    end
endmodule
`default_nettype wire
